//--- inc/uprt_consts.svh
`ifndef UPRT_CONSTS_SVH
`define UPRT_CONSTS_SVH

`define UPRT_OFF_MODE        8'hc0
`define UPRT_OFF_CONTROL     8'hc8
`define UPRT_OFF_RELOAD_LOW  8'hd0
`define UPRT_OFF_RELOAD_HIGH 8'hd4
`define UPRT_OFF_COUNT_LOW   8'hd8
`define UPRT_OFF_COUNT_HIGH  8'hdc
`define UPRT_OFF_IRQ_STATUS  8'he0
`define UPRT_OFF_IRQ_MASK    8'he4

`define UPRT_CTL_OVF_BIT     7
`define UPRT_CTL_EXT_BIT     6
`define UPRT_CTL_RXBAUD_BIT  5
`define UPRT_CTL_TXBAUD_BIT  4
`define UPRT_CTL_RUN_BIT     2
`define UPRT_CTL_SRC_BIT     1
`define UPRT_MODE_UPDN_BIT   0
`define UPRT_MODE_CLKOE_BIT  1

`define UPRT_RST_BYTE        8'h00
`define UPRT_RST_MODE        2'h0
`define UPRT_COUNT_TOP       16'hffff
`define UPRT_TIMER_DIV       3'h6
`define UPRT_CLKOUT_DIV      3'h2

`define UPRT_RESP_OKAY       2'h0
`define UPRT_RESP_SLVERR     2'h2

`endif

//--- inc/uprt_pkg.sv
package uprt_pkg;
	typedef enum logic [2:0] {
		UPRT_SRC_TIMER   = 3'h1,
		UPRT_SRC_COUNTER = 3'h2,
		UPRT_SRC_CLKOUT  = 3'h4
	} uprt_src_t;
	typedef logic [7:0] uprt_byte_t;
endpackage : uprt_pkg

//--- inc/uprt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uprt_tick_if;
	logic                run;
	uprt_pkg::uprt_src_t src;
	logic                tick;
	modport ctl (output run, output src, input tick);
	modport gen (input run, input src, output tick);
endinterface : uprt_tick_if
`default_nettype wire

//--- hw/uprt_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "uprt_consts.svh"
module uprt_tick (
	input  wire logic   clk,
	input  wire logic   sys_rst,
	input  wire logic   pin_i,
	uprt_tick_if.gen    tk
);
	logic [2:0] pre_reg;
	logic       pin_s1_reg;
	logic       pin_s2_reg;
	logic       pin_d_reg;
	wire  [2:0] div;
	wire        pre_hit;
	wire        pin_fall;

	assign div      = (tk.src == uprt_pkg::UPRT_SRC_CLKOUT) ? `UPRT_CLKOUT_DIV : `UPRT_TIMER_DIV;
	assign pre_hit  = (pre_reg == div - 3'h1);
	// events are falling edges, seen after the two-stage synchroniser
	assign pin_fall = pin_d_reg & ~pin_s2_reg;

	always_ff @(posedge clk) begin
		if (sys_rst | ~tk.run | pre_hit) begin
			pre_reg <= 3'h0;
		end else begin
			pre_reg <= pre_reg + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			pin_d_reg  <= 1'b1;
		end else begin
			pin_s1_reg <= pin_i;
			pin_s2_reg <= pin_s1_reg;
			pin_d_reg  <= pin_s2_reg;
		end
	end

	always_comb begin
		case (tk.src)
			uprt_pkg::UPRT_SRC_TIMER:   tk.tick = tk.run & pre_hit;  // see RULE2
			uprt_pkg::UPRT_SRC_COUNTER: tk.tick = tk.run & pin_fall; // see RULE2
			uprt_pkg::UPRT_SRC_CLKOUT:  tk.tick = tk.run & pre_hit;  // see RULE8
			default:                    tk.tick = 1'b0;
		endcase
	end

	a_timer_spacing: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
		(tk.tick && tk.src == uprt_pkg::UPRT_SRC_TIMER && $stable(tk.src) && tk.run)
		|=> !tk.tick [*5])
		else $error("timer tick closer than six clocks");
endmodule : uprt_tick
`default_nettype wire

//--- hw/uprt_top.sv
// Summary of operation
// RULE1: count held in cascaded high/low bytes
// RULE2: source is clock/6 or pin events
// RULE3: count advances only while run set
// RULE4: updown enable takes direction from pin
// RULE5: up wrap from ffff reloads, flags, interrupts
// RULE6: down at reload value loads ffff, flags
// RULE7: external flag toggles per wrap, no interrupt
// RULE8: clock-out square wave, count at clock/2
// RULE9: clock-out reloads on wrap, no interrupt
// RULE10: output toggles each wrap, clock/4(65536-reload)
// RULE11: clock-out drives the count pin
// RULE12: software configures fully before setting run
// RULE13: baud ticks and clock-out share reload
// RULE14: no flag in baud mode; software clears
// RULE15: without updown enable, count up only
`timescale 1ns/1ps
`default_nettype none
`include "uprt_consts.svh"
module uprt_top (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        count_clockout_pin_i,
	output logic             count_clockout_pin_o,
	output logic             count_clockout_pin_oe,
	input  wire logic        direction_pin,
	output logic             baud_tick,
	output logic             irq
);
	uprt_tick_if tk ();

	uprt_pkg::uprt_byte_t count_low_reg;
	uprt_pkg::uprt_byte_t count_high_reg;
	uprt_pkg::uprt_byte_t reload_low_reg;
	uprt_pkg::uprt_byte_t reload_high_reg;
	logic [5:0]  ctrl_reg;
	logic [1:0]  mode_reg;
	logic        ovf_flag_reg;
	logic        ext_flag_reg;
	logic        irq_stat_reg;
	logic        irq_mask_reg;
	logic        dir_s1_reg;
	logic        dir_s2_reg;
	logic        clk_o_reg;
	logic        baud_reg;
	logic        aw_hold_reg;
	logic        w_hold_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic        wstrb0_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;

	// ---- bus slave ----
	wire        do_wr   = aw_hold_reg & w_hold_reg;
	wire        wr_en   = do_wr & wstrb0_reg;
	wire [7:0]  wd      = wdata_reg[7:0];
	wire        wr_ctl  = wr_en & (awaddr_reg == `UPRT_OFF_CONTROL);
	wire        wr_mode = wr_en & (awaddr_reg == `UPRT_OFF_MODE);
	wire        wr_rl   = wr_en & (awaddr_reg == `UPRT_OFF_RELOAD_LOW);
	wire        wr_rh   = wr_en & (awaddr_reg == `UPRT_OFF_RELOAD_HIGH);
	wire        wr_cl   = wr_en & (awaddr_reg == `UPRT_OFF_COUNT_LOW);
	wire        wr_ch   = wr_en & (awaddr_reg == `UPRT_OFF_COUNT_HIGH);
	wire        wr_st   = wr_en & (awaddr_reg == `UPRT_OFF_IRQ_STATUS);
	wire        wr_mk   = wr_en & (awaddr_reg == `UPRT_OFF_IRQ_MASK);
	wire        wr_hit  = (awaddr_reg == `UPRT_OFF_CONTROL) | (awaddr_reg == `UPRT_OFF_MODE)
		| (awaddr_reg == `UPRT_OFF_RELOAD_LOW) | (awaddr_reg == `UPRT_OFF_RELOAD_HIGH)
		| (awaddr_reg == `UPRT_OFF_COUNT_LOW) | (awaddr_reg == `UPRT_OFF_COUNT_HIGH)
		| (awaddr_reg == `UPRT_OFF_IRQ_STATUS) | (awaddr_reg == `UPRT_OFF_IRQ_MASK);
	wire        rd_take = s_axi_arvalid & ~rvalid_reg;
	wire [7:0]  ctl_rd  = {ovf_flag_reg, ext_flag_reg, ctrl_reg};
	wire        rd_hit;
	wire [7:0]  rd_mux;

	assign rd_mux =
		(s_axi_araddr == `UPRT_OFF_CONTROL)     ? ctl_rd :
		(s_axi_araddr == `UPRT_OFF_MODE)        ? {6'h00, mode_reg} :
		(s_axi_araddr == `UPRT_OFF_RELOAD_LOW)  ? reload_low_reg :
		(s_axi_araddr == `UPRT_OFF_RELOAD_HIGH) ? reload_high_reg :
		(s_axi_araddr == `UPRT_OFF_COUNT_LOW)   ? count_low_reg :
		(s_axi_araddr == `UPRT_OFF_COUNT_HIGH)  ? count_high_reg :
		(s_axi_araddr == `UPRT_OFF_IRQ_STATUS)  ? {7'h00, irq_stat_reg} :
		(s_axi_araddr == `UPRT_OFF_IRQ_MASK)    ? {7'h00, irq_mask_reg} : 8'h00;
	assign rd_hit = (s_axi_araddr == `UPRT_OFF_CONTROL) | (s_axi_araddr == `UPRT_OFF_MODE)
		| (s_axi_araddr == `UPRT_OFF_RELOAD_LOW) | (s_axi_araddr == `UPRT_OFF_RELOAD_HIGH)
		| (s_axi_araddr == `UPRT_OFF_COUNT_LOW) | (s_axi_araddr == `UPRT_OFF_COUNT_HIGH)
		| (s_axi_araddr == `UPRT_OFF_IRQ_STATUS) | (s_axi_araddr == `UPRT_OFF_IRQ_MASK);

	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	always_ff @(posedge clk) begin
		if (sys_rst | do_wr) begin
			aw_hold_reg <= 1'b0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_hold_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst | do_wr) begin
			w_hold_reg <= 1'b0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_hold_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb0_reg <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `UPRT_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? `UPRT_RESP_OKAY : `UPRT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `UPRT_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_hit ? `UPRT_RESP_OKAY : `UPRT_RESP_SLVERR;
			rdata_reg  <= {24'h00_0000, rd_mux};
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ---- count engine ----
	wire        clkout   = mode_reg[`UPRT_MODE_CLKOE_BIT];
	wire        updn_en  = mode_reg[`UPRT_MODE_UPDN_BIT];
	wire        baud_any = ctrl_reg[`UPRT_CTL_RXBAUD_BIT] | ctrl_reg[`UPRT_CTL_TXBAUD_BIT];
	wire [15:0] cnt      = {count_high_reg, count_low_reg};
	wire [15:0] reload   = {reload_high_reg, reload_low_reg};
	// pin only steers in updown auto-reload; clock-out and baud always count up
	wire        up       = clkout | baud_any | ~updn_en | dir_s2_reg;  // see RULE4, RULE15
	wire        step     = tk.tick;
	wire        ov_up    = step & up & (cnt == `UPRT_COUNT_TOP);          // see RULE5
	wire        ov_dn    = step & ~up & (cnt == reload);                  // see RULE6
	wire        ov       = ov_up | ov_dn;
	wire        lo_carry = up ? (count_low_reg == 8'hff) : (count_low_reg == 8'h00);
	wire [7:0]  lo_step  = up ? count_low_reg + 8'h01 : count_low_reg - 8'h01;
	wire [7:0]  hi_delta = up ? 8'h01 : 8'hff;
	wire [7:0]  hi_step  = lo_carry ? count_high_reg + hi_delta : count_high_reg;  // see RULE1
	wire [15:0] wrap_val = ov_up ? reload : `UPRT_COUNT_TOP;             // see RULE5, RULE6, RULE9
	wire        set_flag = ov & ~baud_any & ~clkout;                      // see RULE9, RULE14
	wire        tog_ext  = ov & updn_en & ~clkout;                        // see RULE7

	assign tk.run = ctrl_reg[`UPRT_CTL_RUN_BIT];                          // see RULE3
	assign tk.src = clkout ? uprt_pkg::UPRT_SRC_CLKOUT :                  // see RULE8
		ctrl_reg[`UPRT_CTL_SRC_BIT] ? uprt_pkg::UPRT_SRC_COUNTER : uprt_pkg::UPRT_SRC_TIMER;

	uprt_tick u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_i   (count_clockout_pin_i),
		.tk      (tk)
	);

	// software writes to the count beat the running count in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_low_reg  <= `UPRT_RST_BYTE;
			count_high_reg <= `UPRT_RST_BYTE;
		end else begin
			if (wr_cl) begin
				count_low_reg <= wd;
			end else if (step) begin
				count_low_reg <= ov ? wrap_val[7:0] : lo_step;    // see RULE3
			end
			if (wr_ch) begin
				count_high_reg <= wd;
			end else if (step) begin
				count_high_reg <= ov ? wrap_val[15:8] : hi_step;  // see RULE1
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reload_low_reg  <= `UPRT_RST_BYTE;
			reload_high_reg <= `UPRT_RST_BYTE;
			ctrl_reg        <= 6'h00;
			mode_reg        <= `UPRT_RST_MODE;
			irq_mask_reg    <= 1'b0;
		end else begin
			if (wr_rl) reload_low_reg <= wd;
			if (wr_rh) reload_high_reg <= wd;
			if (wr_ctl) ctrl_reg <= wd[5:0];
			if (wr_mode) mode_reg <= wd[1:0];
			if (wr_mk) irq_mask_reg <= wd[0];
		end
	end

	// hardware set outranks a software clear landing in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ovf_flag_reg <= 1'b0;
			ext_flag_reg <= 1'b0;
			irq_stat_reg <= 1'b0;
		end else begin
			ovf_flag_reg <= set_flag | (wr_ctl ? wd[`UPRT_CTL_OVF_BIT] : ovf_flag_reg);  // see RULE14
			ext_flag_reg <= (wr_ctl ? wd[`UPRT_CTL_EXT_BIT] : ext_flag_reg) ^ tog_ext;   // see RULE7
			irq_stat_reg <= set_flag | (irq_stat_reg & ~(wr_st & wd[0]));               // see RULE5
		end
	end

	// two stages before the direction pin is used
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dir_s1_reg <= 1'b1;
			dir_s2_reg <= 1'b1;
		end else begin
			dir_s1_reg <= direction_pin;
			dir_s2_reg <= dir_s1_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_o_reg <= 1'b0;
			baud_reg  <= 1'b0;
		end else begin
			clk_o_reg <= clkout ? clk_o_reg ^ ov : 1'b0;  // see RULE10
			baud_reg  <= ov & baud_any;                   // see RULE13
		end
	end

	assign count_clockout_pin_o  = clk_o_reg;             // see RULE11
	assign count_clockout_pin_oe = clkout;                // see RULE11
	assign baud_tick             = baud_reg;
	assign irq                   = irq_stat_reg & irq_mask_reg;

	// ---- checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_up_wrap_reload: assert property ( // see RULE5
		(ov_up && !wr_cl && !wr_ch) |=> (cnt == $past(reload)))
		else $error("up wrap did not reload");
	a_down_wrap_top: assert property ( // see RULE6
		(ov_dn && !wr_cl && !wr_ch) |=> (cnt == 16'hffff))
		else $error("down wrap did not load ffff");
	a_count_step_up: assert property ( // see RULE1
		(step && up && !ov && !wr_cl && !wr_ch) |=> (cnt == $past(cnt) + 16'h0001))
		else $error("count did not advance by one");
	a_count_hold_idle: assert property ( // see RULE3
		(!tk.run && !wr_cl && !wr_ch) |=> $stable(cnt))
		else $error("count moved while stopped");
	a_flag_not_baud: assert property ( // see RULE14
		($rose(ovf_flag_reg) && !$past(wr_ctl))
		|-> ($past(ov) && !$past(baud_any) && !$past(clkout)))
		else $error("overflow flag set in baud mode");
	a_ext_toggle_wrap: assert property ( // see RULE7
		(ov && updn_en && !clkout && !wr_ctl) |=> (ext_flag_reg != $past(ext_flag_reg)))
		else $error("external flag missed a toggle");
	a_ext_no_irq: assert property ( // see RULE7
		(tog_ext && !set_flag && !irq_stat_reg) |=> !irq_stat_reg)
		else $error("external toggle raised interrupt");
	a_clkout_toggle: assert property ( // see RULE10
		(ov && clkout) |=> (count_clockout_pin_o != $past(count_clockout_pin_o))
		and !$rose(irq_stat_reg))
		else $error("clock-out pin did not toggle cleanly");
	a_updown_dir: assert property ( // see RULE4
		(step && updn_en && !clkout && !baud_any && !dir_s2_reg && !ov && !wr_cl && !wr_ch)
		|=> (cnt == $past(cnt) - 16'h0001))
		else $error("pin low did not count down");
	a_resp_holds: assert property (
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid [*1])
		else $error("write response dropped early");

	c_up_wrap:   cover property (ov_up && !clkout);
	c_down_wrap: cover property (ov_dn);
	c_clkout:    cover property (ov && clkout);
	c_irq_rise:  cover property ($rose(irq));
endmodule : uprt_top
`default_nettype wire

//--- sim/uprt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module uprt_pin_model (
	input  wire logic clk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin_i,
	output logic      dir
);
	logic ext_low;
	initial begin
		ext_low = 1'b0;
		dir = 1'b1;
	end
	// pull-up on the shared pin; the design's output wins while enabled
	assign pin_i = pin_oe ? pin_o : ~ext_low;
	// slow edges, well above the two-stage pin synchroniser
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clk);
			ext_low <= 1'b1;
			repeat (4) @(posedge clk);
			ext_low <= 1'b0;
		end
	endtask : pulses
	task automatic set_dir(input logic up);
		@(posedge clk);
		dir <= up;
		repeat (4) @(posedge clk);
	endtask : set_dir
endmodule : uprt_pin_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uprt_consts.svh"
module testbench;
	logic        clk = 1'b0, sys_rst = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        pin_i, pin_o, pin_oe, dir, baud_tick, irq;
	int          bad_count = 0, compares = 0, cyc = 0;
	always #50 clk = ~clk;
	uprt_top i_uprt_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .count_clockout_pin_i(pin_i), .count_clockout_pin_o(pin_o),
		.count_clockout_pin_oe(pin_oe), .direction_pin(dir), .baud_tick(baud_tick), .irq(irq));
	uprt_pin_model i_uprt_pin_model (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_i(pin_i), .dir(dir));
	task automatic summarize;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// hang guard, far above the several hundred cycles the scenarios need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, `UPRT_RESP_OKAY);
	endtask : w
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, {24'h0, exp});
		chk(r, `UPRT_RESP_OKAY);
	endtask : rc
	task automatic load(input logic [15:0] rl, input logic [15:0] ct);
		w(`UPRT_OFF_RELOAD_LOW, rl[7:0]);
		w(`UPRT_OFF_RELOAD_HIGH, rl[15:8]);
		w(`UPRT_OFF_COUNT_LOW, ct[7:0]);
		w(`UPRT_OFF_COUNT_HIGH, ct[15:8]);
	endtask : load
	task automatic t_reset_map;
		logic [31:0] d;
		logic [1:0]  r;
		rc(`UPRT_OFF_CONTROL, 8'h00);
		rc(`UPRT_OFF_MODE, 8'h00);
		rc(`UPRT_OFF_IRQ_MASK, 8'h00);
		rd(8'hf0, d, r);
		chk(r, `UPRT_RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'hf0, 8'h55, r);
		chk(r, `UPRT_RESP_SLVERR);
		w(`UPRT_OFF_RELOAD_LOW, 8'ha5);
		rc(`UPRT_OFF_RELOAD_LOW, 8'ha5);
		// a write without byte lane 0 is answered but must not land
		wstrb <= 4'h0;
		w(`UPRT_OFF_RELOAD_LOW, 8'h5a);
		wstrb <= 4'hf;
		rc(`UPRT_OFF_RELOAD_LOW, 8'ha5);
		chk({irq, pin_oe}, 2'b00);
	endtask : t_reset_map
	task automatic t_timer_rate;
		logic [31:0] a, b, c, d;
		logic [1:0]  r;
		load(16'h0000, 16'h0000);
		w(`UPRT_OFF_CONTROL, 8'h04);
		rd(`UPRT_OFF_COUNT_LOW, a, r);
		// 57 idle edges put the two sampling edges exactly 60 clocks apart
		repeat (57) @(posedge clk);
		rd(`UPRT_OFF_COUNT_LOW, b, r);
		chk(b - a, 32'h0000000a);
		w(`UPRT_OFF_CONTROL, 8'h00);
		rd(`UPRT_OFF_COUNT_LOW, c, r);
		repeat (20) @(posedge clk);
		rd(`UPRT_OFF_COUNT_LOW, d, r);
		chk(d, c);
		load(16'h0000, 16'h00ff);
		w(`UPRT_OFF_CONTROL, 8'h04);
		repeat (15) @(posedge clk);
		rc(`UPRT_OFF_COUNT_HIGH, 8'h01);
		w(`UPRT_OFF_CONTROL, 8'h00);
	endtask : t_timer_rate
	task automatic t_up_wrap;
		i_uprt_pin_model.set_dir(1'b0);
		load(16'h1234, 16'hfffe);
		w(`UPRT_OFF_IRQ_MASK, 8'h01);
		w(`UPRT_OFF_CONTROL, 8'h04);
		repeat (30) @(posedge clk);
		rc(`UPRT_OFF_CONTROL, 8'h84);
		rc(`UPRT_OFF_COUNT_HIGH, 8'h12);
		chk(irq, 1'b1);
		w(`UPRT_OFF_IRQ_MASK, 8'h00);
		chk(irq, 1'b0);
		w(`UPRT_OFF_IRQ_STATUS, 8'h01);
		w(`UPRT_OFF_IRQ_MASK, 8'h01);
		chk(irq, 1'b0);
		w(`UPRT_OFF_CONTROL, 8'h00);
		rc(`UPRT_OFF_CONTROL, 8'h00);
	endtask : t_up_wrap
	task automatic t_down;
		w(`UPRT_OFF_MODE, 8'h01);
		load(16'h0010, 16'h0012);
		w(`UPRT_OFF_CONTROL, 8'h04);
		repeat (40) @(posedge clk);
		rc(`UPRT_OFF_COUNT_HIGH, 8'hff);
		rc(`UPRT_OFF_CONTROL, 8'hc4);
		w(`UPRT_OFF_CONTROL, 8'h00);
		w(`UPRT_OFF_MODE, 8'h00);
		w(`UPRT_OFF_IRQ_STATUS, 8'h01);
		i_uprt_pin_model.set_dir(1'b1);
	endtask : t_down
	task automatic t_clockout;
		int   tog, bt;
		logic prev;
		tog = 0;
		bt = 0;
		w(`UPRT_OFF_MODE, 8'h02);
		w(`UPRT_OFF_CONTROL, 8'h00);
		load(16'hfffe, 16'hfffe);
		w(`UPRT_OFF_CONTROL, 8'h14);
		chk(pin_oe, 1'b1);
		repeat (10) @(posedge clk);
		prev = pin_o;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			if (pin_o !== prev) tog++;
			prev = pin_o;
			if (baud_tick === 1'b1) bt++;
		end
		// reload fffe gives 4*(65536-65534) = 8 clocks per period
		chk(tog, 10);
		chk(bt, 10);
		chk(pin_i, pin_o);
		rc(`UPRT_OFF_CONTROL, 8'h14);
		rc(`UPRT_OFF_IRQ_STATUS, 8'h00);
		// clock-out alone, no baud select: its wraps still raise no flag
		w(`UPRT_OFF_CONTROL, 8'h04);
		repeat (20) @(posedge clk);
		rc(`UPRT_OFF_CONTROL, 8'h04);
		rc(`UPRT_OFF_IRQ_STATUS, 8'h00);
		w(`UPRT_OFF_CONTROL, 8'h00);
		w(`UPRT_OFF_MODE, 8'h00);
		chk(pin_oe, 1'b0);
	endtask : t_clockout
	task automatic t_baud_ext;
		int bt;
		bt = 0;
		w(`UPRT_OFF_MODE, 8'h01);
		load(16'h0000, 16'hffff);
		w(`UPRT_OFF_CONTROL, 8'h24);
		// one wrap only: reload 0000 leaves 65536 ticks to the next
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (baud_tick === 1'b1) bt++;
		end
		chk(bt, 1);
		rc(`UPRT_OFF_CONTROL, 8'h64);
		rc(`UPRT_OFF_IRQ_STATUS, 8'h00);
		w(`UPRT_OFF_CONTROL, 8'h00);
		w(`UPRT_OFF_MODE, 8'h00);
	endtask : t_baud_ext
	task automatic t_mid_reset;
		w(`UPRT_OFF_RELOAD_LOW, 8'h3c);
		w(`UPRT_OFF_MODE, 8'h02);
		w(`UPRT_OFF_CONTROL, 8'h04);
		repeat (10) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		chk({irq, pin_oe, pin_o, baud_tick}, 4'h0);
		rc(`UPRT_OFF_CONTROL, 8'h00);
		rc(`UPRT_OFF_MODE, 8'h00);
		rc(`UPRT_OFF_COUNT_LOW, 8'h00);
		rc(`UPRT_OFF_RELOAD_LOW, 8'h00);
	endtask : t_mid_reset
	task automatic t_counter;
		load(16'h0000, 16'h0000);
		w(`UPRT_OFF_CONTROL, 8'h06);
		i_uprt_pin_model.pulses(3);
		repeat (10) @(posedge clk);
		rc(`UPRT_OFF_COUNT_LOW, 8'h03);
		w(`UPRT_OFF_CONTROL, 8'h00);
	endtask : t_counter
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset_map();
		t_timer_rate();
		t_up_wrap();
		t_down();
		t_clockout();
		t_baud_ext();
		t_counter();
		t_mid_reset();
		summarize();
	end
endmodule : testbench
`default_nettype wire
